// file: logic/hms_sequencer.v
// Purpose: homing sequencer for methods 27 to 30, 33, 34 and 35
// Assumes: switch, limit and index inputs asynchronous to sys_clk
// Notes: motion profile (ramps) belongs to the drive; this block
// Notes: only commands direction, speed class and stop points
`timescale 1ns/1ns
`default_nettype none
`include "hms_map.vh"

module hms_sequencer #(
	parameter POS_W = 32
) (
	// clock and reset
	input wire sys_clk,
	input wire rst_n,
	// register port
	input wire [`HMS_ADDR_W-1:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	// field inputs
	input wire home_switch,
	input wire rev_limit,
	input wire index_pulse,
	// motion commands, position preset, completion and interrupt
	output reg motion_run,
	output reg motion_rev,
	output reg motion_high_speed,
	output reg position_preset,
	output reg [POS_W-1:0] user_position,
	output reg home_done_output,
	output wire irq
);

	// ****************************************************************
	// synchronisers and edge strobes
	// ****************************************************************
	reg [2:0] sync1;
	reg [2:0] sync2;
	reg [2:0] sync3;
	wire hs_lvl = sync2[0];
	wire lim_lvl = sync2[1];
	wire hs_rise = sync2[0] & ~sync3[0];
	wire hs_fall = ~sync2[0] & sync3[0];
	wire idx_rise = sync2[2] & ~sync3[2];

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1 <= `HMS_SYNC_RST;
			sync2 <= `HMS_SYNC_RST;
			sync3 <= `HMS_SYNC_RST;
		end else begin
			// first stage is read by the second stage only
			sync1 <= {index_pulse, rev_limit, home_switch};
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// ****************************************************************
	// trajectory table
	// ****************************************************************
	// segment = {valid, reverse, high speed, stop event}
	function [4:0] seg_of;
		input [2:0] mi;
		input [1:0] pth;
		input [1:0] stp;
		begin
			case ({mi, pth, stp})
			{`HMS_MI_27, `HMS_P_NORM, `HMS_S0}:
				seg_of = `HMS_SEG(`HMS_REV, `HMS_HI, `HMS_EV_RISE);
			{`HMS_MI_27, `HMS_P_NORM, `HMS_S1}:
				seg_of = `HMS_SEG(`HMS_FWD, `HMS_LO, `HMS_EV_FALL);
			{`HMS_MI_27, `HMS_P_LIM, `HMS_S0}:
				seg_of = `HMS_SEG(`HMS_FWD, `HMS_HI, `HMS_EV_RISE);
			{`HMS_MI_27, `HMS_P_LIM, `HMS_S1}:
				seg_of = `HMS_SEG(`HMS_FWD, `HMS_LO, `HMS_EV_FALL);
			{`HMS_MI_27, `HMS_P_LIM, `HMS_S2}:
				seg_of = `HMS_SEG(`HMS_REV, `HMS_LO, `HMS_EV_RISE);
			{`HMS_MI_27, `HMS_P_LIM, `HMS_S3}:
				seg_of = `HMS_SEG(`HMS_FWD, `HMS_LO, `HMS_EV_FALL);
			{`HMS_MI_27, `HMS_P_ACT, `HMS_S0}:
				seg_of = `HMS_SEG(`HMS_FWD, `HMS_LO, `HMS_EV_FALL);
			{`HMS_MI_28, `HMS_P_NORM, `HMS_S0}:
				seg_of = `HMS_SEG(`HMS_REV, `HMS_HI, `HMS_EV_RISE);
			{`HMS_MI_28, `HMS_P_NORM, `HMS_S1}:
				seg_of = `HMS_SEG(`HMS_FWD, `HMS_LO, `HMS_EV_FALL);
			{`HMS_MI_28, `HMS_P_NORM, `HMS_S2}:
				seg_of = `HMS_SEG(`HMS_REV, `HMS_LO, `HMS_EV_RISE);
			{`HMS_MI_28, `HMS_P_LIM, `HMS_S0}:
				seg_of = `HMS_SEG(`HMS_FWD, `HMS_HI, `HMS_EV_RISE);
			{`HMS_MI_28, `HMS_P_LIM, `HMS_S1}:
				seg_of = `HMS_SEG(`HMS_FWD, `HMS_LO, `HMS_EV_FALL);
			{`HMS_MI_28, `HMS_P_LIM, `HMS_S2}:
				seg_of = `HMS_SEG(`HMS_REV, `HMS_LO, `HMS_EV_RISE);
			{`HMS_MI_28, `HMS_P_ACT, `HMS_S0}:
				seg_of = `HMS_SEG(`HMS_FWD, `HMS_LO, `HMS_EV_FALL);
			{`HMS_MI_28, `HMS_P_ACT, `HMS_S1}:
				seg_of = `HMS_SEG(`HMS_REV, `HMS_LO, `HMS_EV_RISE);
			{`HMS_MI_29, `HMS_P_NORM, `HMS_S0}:
				seg_of = `HMS_SEG(`HMS_REV, `HMS_HI, `HMS_EV_FALL);
			{`HMS_MI_29, `HMS_P_NORM, `HMS_S1}:
				seg_of = `HMS_SEG(`HMS_FWD, `HMS_LO, `HMS_EV_RISE);
			{`HMS_MI_29, `HMS_P_LIM, `HMS_S0}:
				seg_of = `HMS_SEG(`HMS_FWD, `HMS_HI, `HMS_EV_RISE);
			{`HMS_MI_29, `HMS_P_LIM, `HMS_S1}:
				seg_of = `HMS_SEG(`HMS_REV, `HMS_LO, `HMS_EV_FALL);
			{`HMS_MI_29, `HMS_P_LIM, `HMS_S2}:
				seg_of = `HMS_SEG(`HMS_FWD, `HMS_LO, `HMS_EV_RISE);
			{`HMS_MI_29, `HMS_P_ACT, `HMS_S0}:
				seg_of = `HMS_SEG(`HMS_REV, `HMS_LO, `HMS_EV_FALL);
			{`HMS_MI_29, `HMS_P_ACT, `HMS_S1}:
				seg_of = `HMS_SEG(`HMS_FWD, `HMS_LO, `HMS_EV_RISE);
			{`HMS_MI_30, `HMS_P_NORM, `HMS_S0}:
				seg_of = `HMS_SEG(`HMS_REV, `HMS_HI, `HMS_EV_RISE);
			{`HMS_MI_30, `HMS_P_NORM, `HMS_S1}:
				seg_of = `HMS_SEG(`HMS_REV, `HMS_LO, `HMS_EV_FALL);
			{`HMS_MI_30, `HMS_P_NORM, `HMS_S2}:
				seg_of = `HMS_SEG(`HMS_FWD, `HMS_LO, `HMS_EV_RISE);
			{`HMS_MI_30, `HMS_P_NORM, `HMS_S3}:
				seg_of = `HMS_SEG(`HMS_REV, `HMS_LO, `HMS_EV_FALL);
			{`HMS_MI_30, `HMS_P_LIM, `HMS_S0}:
				seg_of = `HMS_SEG(`HMS_FWD, `HMS_HI, `HMS_EV_RISE);
			{`HMS_MI_30, `HMS_P_LIM, `HMS_S1}:
				seg_of = `HMS_SEG(`HMS_REV, `HMS_LO, `HMS_EV_FALL);
			{`HMS_MI_30, `HMS_P_ACT, `HMS_S0}:
				seg_of = `HMS_SEG(`HMS_REV, `HMS_LO, `HMS_EV_FALL);
			// index searches ignore the switch
			{`HMS_MI_33, `HMS_P_NORM, `HMS_S0}:
				seg_of = `HMS_SEG(`HMS_REV, `HMS_LO, `HMS_EV_IDX);
			{`HMS_MI_34, `HMS_P_NORM, `HMS_S0}:
				seg_of = `HMS_SEG(`HMS_FWD, `HMS_LO, `HMS_EV_IDX);
			default:
				seg_of = `HMS_SEG_NONE;
			endcase
		end
	endfunction

	// ****************************************************************
	// registers and decode
	// ****************************************************************
	localparam ST_IDLE = 1'b0;
	localparam ST_RUN = 1'b1;

	reg [5:0] homing_method_select;
	reg [POS_W-1:0] home_offset;
	reg [`HMS_IRQ_W-1:0] irq_stat;
	reg [`HMS_IRQ_W-1:0] irq_mask;
	reg state;
	reg [2:0] midx;
	reg [1:0] path;
	reg [1:0] step;
	reg failed;
	reg refused;

	wire wr_ctrl = reg_wr && reg_addr == `HMS_OFS_CTRL;
	wire start_req = wr_ctrl && reg_wdata[`HMS_CTRL_START];
	wire abort_req = wr_ctrl && reg_wdata[`HMS_CTRL_ABORT];
	wire [5:0] new_method = reg_wdata[`HMS_METHOD_HI:`HMS_METHOD_LO];
	wire [4:0] seg = seg_of(midx, path, step);
	wire [4:0] seg_next = seg_of(midx, path, step + 2'h1);
	wire [1:0] seg_ev = seg[1:0];
	wire seg_rev = seg[3];
	wire ev_hit = (seg_ev == `HMS_EV_RISE && hs_rise) ||
		(seg_ev == `HMS_EV_FALL && hs_fall) ||
		(seg_ev == `HMS_EV_IDX && idx_rise);
	// only the switch methods have a limit branch
	wire sw_method = midx <= `HMS_MI_30;
	wire lim_hit = lim_lvl && seg_rev;

	// methods outside the table, 31 and 32 among them, are refused
	reg method_ok;
	reg [2:0] next_midx;
	always @* begin
		method_ok = 1'b1;
		next_midx = `HMS_MI_27;
		case (new_method)
		`HMS_M27: next_midx = `HMS_MI_27;
		`HMS_M28: next_midx = `HMS_MI_28;
		`HMS_M29: next_midx = `HMS_MI_29;
		`HMS_M30: next_midx = `HMS_MI_30;
		`HMS_M33: next_midx = `HMS_MI_33;
		`HMS_M34: next_midx = `HMS_MI_34;
		`HMS_M35: next_midx = `HMS_MI_27;
		default: method_ok = 1'b0;
		endcase
	end

	// ****************************************************************
	// sequencer
	// ****************************************************************
	reg ev_done;
	reg ev_fail;
	reg ev_refused;

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			midx <= `HMS_MI_27;
			path <= `HMS_P_NORM;
			step <= `HMS_S0;
			homing_method_select <= `HMS_METHOD_RST;
			home_done_output <= 1'b0;
			failed <= 1'b0;
			refused <= 1'b0;
			position_preset <= 1'b0;
			user_position <= `HMS_POS_RST;
			ev_done <= 1'b0;
			ev_fail <= 1'b0;
			ev_refused <= 1'b0;
		end else begin
			position_preset <= 1'b0;
			ev_done <= 1'b0;
			ev_fail <= 1'b0;
			ev_refused <= 1'b0;
			if (wr_ctrl)
				homing_method_select <= new_method;
			case (state)
			ST_IDLE: begin
				if (start_req && !method_ok) begin
					refused <= 1'b1;
					home_done_output <= 1'b0;
					ev_refused <= 1'b1;
				end else if (start_req && new_method == `HMS_M35) begin
					user_position <= home_offset;
					position_preset <= 1'b1;
					home_done_output <= 1'b1;
					failed <= 1'b0;
					refused <= 1'b0;
					ev_done <= 1'b1;
				end else if (start_req) begin
					state <= ST_RUN;
					midx <= next_midx;
					step <= `HMS_S0;
					// switch already on at start picks the short path
					if (next_midx <= `HMS_MI_30 && hs_lvl)
						path <= `HMS_P_ACT;
					else
						path <= `HMS_P_NORM;
					home_done_output <= 1'b0;
					failed <= 1'b0;
					refused <= 1'b0;
				end
			end
			ST_RUN: begin
				if (abort_req) begin
					state <= ST_IDLE;
					failed <= 1'b1;
					ev_fail <= 1'b1;
				end else if (lim_hit) begin
					if (sw_method && path == `HMS_P_NORM) begin
						path <= `HMS_P_LIM;
						step <= `HMS_S0;
					end else begin
						// a second limit, a limit on the active path or a limit in the reverse index search (method 33) means no home was found
						state <= ST_IDLE;
						failed <= 1'b1;
						ev_fail <= 1'b1;
					end
				end else if (ev_hit) begin
					if (seg_next[4] && step != `HMS_S3)
						step <= step + 2'h1;
					else begin
						state <= ST_IDLE;
						home_done_output <= 1'b1;
						ev_done <= 1'b1;
					end
				end
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	// stop takes effect on the event edge itself, no extra cycle
	always @* begin
		motion_run = state == ST_RUN && !ev_hit && !lim_hit;
		motion_rev = motion_run && seg_rev;
		motion_high_speed = motion_run && seg[2];
	end

	// ****************************************************************
	// register writes, interrupts and read port
	// ****************************************************************
	wire [`HMS_IRQ_W-1:0] irq_events = {ev_refused, ev_fail, ev_done};
	wire [`HMS_IRQ_W-1:0] irq_clr = (reg_wr &&
		reg_addr == `HMS_OFS_IRQ_STAT) ? reg_wdata[`HMS_IRQ_W-1:0] :
		`HMS_IRQ_RST;

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			home_offset <= `HMS_POS_RST;
			irq_stat <= `HMS_IRQ_RST;
			irq_mask <= `HMS_IRQ_RST;
			reg_rdata <= `HMS_RDATA_RST;
		end else begin
			if (reg_wr && reg_addr == `HMS_OFS_HOME_OFFSET)
				home_offset <= reg_wdata[POS_W-1:0];
			if (reg_wr && reg_addr == `HMS_OFS_IRQ_MASK)
				irq_mask <= reg_wdata[`HMS_IRQ_W-1:0];
			// a new event outranks a clear in the same cycle
			irq_stat <= (irq_stat & ~irq_clr) | irq_events;
			reg_rdata <= `HMS_RDATA_RST;
			if (reg_rd) begin
				case (reg_addr)
				`HMS_OFS_CTRL:
					reg_rdata[`HMS_METHOD_HI:`HMS_METHOD_LO] <=
						homing_method_select;
				`HMS_OFS_STATUS:
					reg_rdata[`HMS_ST_REFUSED:`HMS_ST_BUSY] <=
						{refused, failed, home_done_output, state};
				`HMS_OFS_HOME_OFFSET:
					reg_rdata[POS_W-1:0] <= home_offset;
				`HMS_OFS_USER_POSITION:
					reg_rdata[POS_W-1:0] <= user_position;
				`HMS_OFS_IRQ_STAT:
					reg_rdata[`HMS_IRQ_W-1:0] <= irq_stat;
				`HMS_OFS_IRQ_MASK:
					reg_rdata[`HMS_IRQ_W-1:0] <= irq_mask;
				default:
					reg_rdata <= `HMS_RDATA_RST;
				endcase
			end
		end
	end

	assign irq = |(irq_stat & irq_mask);

endmodule // hms_sequencer

`default_nettype wire

// file: logic/hms_map.vh
// Purpose: constants for the homing method sequencer
// Assumes: included by logic/hms_sequencer.v and by its assertion and bench files
// Notes: byte offsets of the register port, field layout, table codes
`ifndef HMS_MAP_VH
`define HMS_MAP_VH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define HMS_ADDR_W 8
`define HMS_OFS_CTRL 8'h00
`define HMS_OFS_STATUS 8'h04
`define HMS_OFS_HOME_OFFSET 8'h08
`define HMS_OFS_USER_POSITION 8'h0c
`define HMS_OFS_IRQ_STAT 8'h10
`define HMS_OFS_IRQ_MASK 8'h14

// ****************************************************************
// control and status fields
// ****************************************************************
`define HMS_CTRL_START 0
`define HMS_CTRL_ABORT 1
`define HMS_METHOD_LO 8
`define HMS_METHOD_HI 13
`define HMS_METHOD_RST 6'h00
`define HMS_ST_BUSY 0
`define HMS_ST_DONE 1
`define HMS_ST_FAIL 2
`define HMS_ST_REFUSED 3
`define HMS_IRQ_W 3
`define HMS_IRQ_DONE 0
`define HMS_IRQ_FAIL 1
`define HMS_IRQ_REFUSED 2
`define HMS_IRQ_RST 3'h0
`define HMS_POS_RST 32'h0000_0000
`define HMS_RDATA_RST 32'h0000_0000
`define HMS_SYNC_RST 3'h0

// ****************************************************************
// homing method numbers
// ****************************************************************
`define HMS_M27 6'h1b
`define HMS_M28 6'h1c
`define HMS_M29 6'h1d
`define HMS_M30 6'h1e
`define HMS_M33 6'h21
`define HMS_M34 6'h22
`define HMS_M35 6'h23

// ****************************************************************
// trajectory table: method index, path, step, segment
// ****************************************************************
`define HMS_MI_27 3'h0
`define HMS_MI_28 3'h1
`define HMS_MI_29 3'h2
`define HMS_MI_30 3'h3
`define HMS_MI_33 3'h6
`define HMS_MI_34 3'h7
`define HMS_P_NORM 2'h0
`define HMS_P_LIM 2'h1
`define HMS_P_ACT 2'h2
`define HMS_S0 2'h0
`define HMS_S1 2'h1
`define HMS_S2 2'h2
`define HMS_S3 2'h3
`define HMS_EV_RISE 2'h0
`define HMS_EV_FALL 2'h1
`define HMS_EV_IDX 2'h2
`define HMS_FWD 1'b0
`define HMS_REV 1'b1
`define HMS_LO 1'b0
`define HMS_HI 1'b1
`define HMS_SEG_NONE 5'h00
`define HMS_SEG(d, s, e) {1'b1, d, s, e}

`endif

// file: tb/hms_sequencer_asserts.sv
// Purpose: port-level assertions for hms_sequencer
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound to every instance of the sequencer
`timescale 1ns/1ns
`default_nettype none
`include "hms_map.vh"
module hms_sequencer_chk #(
	parameter POS_W = 32
) (
	// clock and reset
	input wire sys_clk,
	input wire rst_n,
	// register port
	input wire [`HMS_ADDR_W-1:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_rdata,
	// field inputs, motion, position, completion and interrupt outputs
	input wire home_switch,
	input wire rev_limit,
	input wire index_pulse,
	input wire motion_run,
	input wire motion_rev,
	input wire motion_high_speed,
	input wire position_preset,
	input wire [POS_W-1:0] user_position,
	input wire home_done_output,
	input wire irq
);
	// ******
	// checks
	// ******
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	wire start = reg_wr && reg_addr == `HMS_OFS_CTRL && reg_wdata[0];
	wire [5:0] meth = reg_wdata[13:8];
	// a stop not caused by a write needs a pin change two edges back
	property p_stop_cause;
		$fell(motion_run) && !$past(reg_wr) |->
			$past(home_switch, 2) != $past(home_switch, 3) ||
			$past(rev_limit, 2) != $past(rev_limit, 3) ||
			$past(index_pulse, 2) != $past(index_pulse, 3);
	endproperty
	a_stop_cause: assert property (p_stop_cause)
		else $error("motion stopped without an input edge");
	property p_preset_once;
		position_preset |=> !position_preset;
	endproperty
	a_preset_once: assert property (p_preset_once)
		else $error("position preset longer than one cycle");
	property p_m35;
		start && meth == `HMS_M35 && !motion_run &&
			!$past(motion_run) |=> position_preset && !motion_run;
	endproperty
	a_m35: assert property (p_m35)
		else $error("current position not taken as home");
	property p_preset_done;
		position_preset |-> home_done_output && !motion_run;
	endproperty
	a_preset_done: assert property (p_preset_done)
		else $error("preset without completion");
	property p_refuse;
		start && (meth == 6'h1f || meth == 6'h20) && !motion_run &&
			!$past(motion_run) |=>
			(!home_done_output && !motion_run) [*2];
	endproperty
	a_refuse: assert property (p_refuse)
		else $error("undefined method started or completed");
	property p_done_rise;
		$rose(home_done_output) |-> !motion_run && !$past(motion_run);
	endproperty
	a_done_rise: assert property (p_done_rise)
		else $error("completion while moving");
	property p_done_hold;
		home_done_output && !reg_wr |=> home_done_output;
	endproperty
	a_done_hold: assert property (p_done_hold)
		else $error("completion dropped without a write");
	property p_run_not_done;
		motion_run |-> !home_done_output;
	endproperty
	a_run_not_done: assert property (p_run_not_done)
		else $error("completion high during motion");
	property p_idle_quiet;
		!motion_run |-> !motion_rev && !motion_high_speed;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet)
		else $error("direction or speed set while stopped");
	c_done: cover property ($rose(home_done_output));
	c_preset: cover property (position_preset);
	c_turn: cover property (motion_run && motion_rev ##1 !motion_run
		##1 motion_run && !motion_rev && motion_high_speed);
endmodule // hms_sequencer_chk

bind hms_sequencer hms_sequencer_chk #(.POS_W(POS_W)) u_chk (
	.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .home_switch(home_switch),
	.rev_limit(rev_limit), .index_pulse(index_pulse),
	.motion_run(motion_run), .motion_rev(motion_rev),
	.motion_high_speed(motion_high_speed),
	.position_preset(position_preset), .user_position(user_position),
	.home_done_output(home_done_output), .irq(irq));
`default_nettype wire

// file: tb/hms_motor_model.sv
// Purpose: behavioural axis with home switch, reverse limit, index
// Assumes: one step per clock, four steps at high speed
// Notes: switch band 100..199, limit at or below 0, index every 64
`timescale 1ns/1ns
`default_nettype none
module hms_motor_model (
	// clock and position load
	input wire logic sys_clk,
	input wire logic load,
	input wire logic signed [31:0] load_pos,
	// motion commands
	input wire logic motion_run,
	input wire logic motion_rev,
	input wire logic motion_high_speed,
	// field signals
	output var int pos,
	output logic home_switch,
	output logic rev_limit,
	output logic index_pulse
);
	// ******
	// axis
	// ******
	int step;
	assign step = motion_high_speed ? 4 : 1;
	always @(posedge sys_clk) begin
		if (load)
			pos <= load_pos;
		else if (motion_run)
			pos <= motion_rev ? pos - step : pos + step;
	end
	assign home_switch = pos >= 100 && pos <= 199;
	assign rev_limit = pos <= 0;
	// wide enough to be seen at four steps a cycle
	assign index_pulse = (pos & 63) < 4;
endmodule // hms_motor_model
`default_nettype wire

// file: tb/test_hms_sequencer.sv
// Purpose: self-checking bench for hms_sequencer
// Assumes: motor model closes the loop on the field inputs
// Notes: segment code is {reverse, high speed}, one bit each
`timescale 1ns/1ns
`default_nettype none
`include "hms_map.vh"
module test_hms_sequencer;
	// ******
	// setup
	// ******
	logic sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, load = 1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000, rd;
	logic signed [31:0] load_pos = 300;
	wire [31:0] reg_rdata, user_position;
	wire home_switch, rev_limit, index_pulse, motion_run, motion_rev;
	wire motion_high_speed, position_preset, home_done_output, irq;
	int pos, num_errors = 0, cmp_count = 0;
	logic [1:0] segs[$];
	logic last_run = 0;
	logic [1:0] last_code = 2'h0;
	hms_sequencer uut (.sys_clk(sys_clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .home_switch(home_switch),
		.rev_limit(rev_limit), .index_pulse(index_pulse),
		.motion_run(motion_run), .motion_rev(motion_rev),
		.motion_high_speed(motion_high_speed),
		.position_preset(position_preset), .user_position(user_position),
		.home_done_output(home_done_output), .irq(irq));
	hms_motor_model motor (.sys_clk(sys_clk), .load(load),
		.load_pos(load_pos), .motion_run(motion_run),
		.motion_rev(motion_rev), .motion_high_speed(motion_high_speed),
		.pos(pos), .home_switch(home_switch), .rev_limit(rev_limit),
		.index_pulse(index_pulse));
	initial begin
		forever #2 sys_clk = ~sys_clk;
	end
	// a new segment is a start of motion or a change of code
	always @(posedge sys_clk) begin
		if (motion_run === 1'b1 && (!last_run ||
			{motion_rev, motion_high_speed} != last_code))
			segs.push_back({motion_rev, motion_high_speed});
		last_run <= motion_run;
		last_code <= {motion_rev, motion_high_speed};
	end
	// ******
	// tasks
	// ******
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rdr(input logic [7:0] a);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 rd = reg_rdata;
	endtask
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic home(input logic [5:0] m, input int p0,
		input logic [15:0] ex, input int n, input int stop);
		@(posedge sys_clk);
		load_pos <= p0;
		load <= 1'b1;
		@(posedge sys_clk);
		load <= 1'b0;
		repeat (6) @(posedge sys_clk);
		segs.delete();
		wr(`HMS_OFS_CTRL, {18'h0, m, 8'h01});
		for (int i = 0; i < 1000 && home_done_output !== 1'b1; i++)
			@(posedge sys_clk);
		#1;
		chk("done", 1, home_done_output);
		chk("seg_count", n, segs.size());
		for (int i = 0; i < n && i < segs.size(); i++)
			chk("segment", ex[2*i +: 2], segs[i]);
		chk("stop_pos", 1, (pos - stop) <= 5 && (stop - pos) <= 5);
	endtask
	// ******
	// scenarios
	// ******
	task automatic t_m27;
		home(`HMS_M27, 300, 16'h0003, 2, 200);
		home(`HMS_M27, 50, 16'h0087, 5, 200);
		home(`HMS_M27, 150, 16'h0000, 1, 200);
	endtask
	task automatic t_m28;
		home(`HMS_M28, 300, 16'h0023, 3, 199);
		home(`HMS_M28, 50, 16'h0087, 4, 199);
		home(`HMS_M28, 150, 16'h0008, 2, 199);
	endtask
	task automatic t_m29;
		home(`HMS_M29, 300, 16'h0003, 2, 100);
		home(`HMS_M29, 50, 16'h0027, 4, 100);
		home(`HMS_M29, 150, 16'h0002, 2, 100);
	endtask
	task automatic t_m30;
		home(`HMS_M30, 300, 16'h008b, 4, 99);
		home(`HMS_M30, 50, 16'h0027, 3, 99);
		home(`HMS_M30, 150, 16'h0002, 1, 99);
	endtask
	task automatic t_index;
		home(`HMS_M33, 300, 16'h0002, 1, 259);
		home(`HMS_M34, 300, 16'h0000, 1, 320);
	endtask
	task automatic t_m35;
		int p;
		p = pos;
		wr(`HMS_OFS_HOME_OFFSET, 32'h1234_5678);
		wr(`HMS_OFS_CTRL, {18'h0, `HMS_M35, 8'h01});
		// preset pulse stands only in the cycle after the start write
		chk("preset", 1, position_preset);
		chk("user_position_port", 32'h1234_5678, user_position);
		rdr(`HMS_OFS_USER_POSITION);
		chk("user_position", 32'h1234_5678, rd);
		chk("preset_end", 0, position_preset);
		chk("done", 1, home_done_output);
		chk("no_motion", p, pos);
	endtask
	task automatic t_refuse;
		logic [5:0] ms[4] = '{6'h1f, 6'h20, 6'h1a, 6'h3f};
		wr(`HMS_OFS_IRQ_STAT, 32'h0000_0007);
		wr(`HMS_OFS_IRQ_MASK, 32'h0000_0000);
		foreach (ms[i]) begin
			wr(`HMS_OFS_CTRL, {18'h0, ms[i], 8'h01});
			rdr(`HMS_OFS_STATUS);
			chk("status", 32'h0000_0008, rd);
			chk("done", 0, home_done_output);
		end
		chk("irq_masked", 0, irq);
		rdr(`HMS_OFS_IRQ_STAT);
		chk("irq_stat", 32'h0000_0004, rd);
		wr(`HMS_OFS_IRQ_MASK, 32'h0000_0004);
		chk("irq", 1, irq);
		wr(`HMS_OFS_IRQ_STAT, 32'h0000_0004);
		chk("irq_clear", 0, irq);
		rdr(8'h20);
		chk("unmapped", 0, rd);
	endtask
	task automatic t_abort;
		wr(`HMS_OFS_CTRL, {18'h0, `HMS_M34, 8'h01});
		chk("run", 1, motion_run);
		wr(`HMS_OFS_CTRL, {18'h0, `HMS_M34, 8'h02});
		chk("stopped", 0, motion_run);
		rdr(`HMS_OFS_STATUS);
		chk("fail", 1, rd[2]);
		chk("done", 0, home_done_output);
		// index search that meets the reverse limit must fail
		@(posedge sys_clk);
		load_pos <= 2;
		load <= 1'b1;
		@(posedge sys_clk);
		load <= 1'b0;
		repeat (6) @(posedge sys_clk);
		wr(`HMS_OFS_CTRL, {18'h0, `HMS_M33, 8'h01});
		repeat (20) @(posedge sys_clk);
		rdr(`HMS_OFS_STATUS);
		chk("limit_fail", 32'h0000_0004, rd);
		chk("limit_stop", 0, motion_run);
	endtask
	task automatic finish_test;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_m27();
		t_m28();
		t_m29();
		t_m30();
		t_index();
		t_m35();
		t_refuse();
		t_abort();
		finish_test();
	end
	// whole run is well under a tenth of this span
	initial begin
		#300000;
		num_errors++;
		finish_test();
	end
endmodule // test_hms_sequencer
`default_nettype wire
